// >>> hw/ofr_cfg.svh
`ifndef OFR_CFG_SVH
`define OFR_CFG_SVH

`define OFR_CMD_OC_RESP      8'h47
`define OFR_CMD_UV_RESP      8'h45
`define OFR_OC_RESP_RST      8'h00
`define OFR_UV_RESP_RST      8'h00
`define OFR_RESP_HI          7
`define OFR_RESP_LO          6
`define OFR_RETRY_HI         5
`define OFR_RETRY_LO         3
`define OFR_DLY_HI           2
`define OFR_DLY_LO           0
`define OFR_RETRY_FOREVER    3'h7
`define OFR_CLK_PERIOD_NS    50
`define OFR_DLY_STEP_NS      10000
`define OFR_DLY_STEP_CYC     ((`OFR_DLY_STEP_NS + `OFR_CLK_PERIOD_NS - 1) / `OFR_CLK_PERIOD_NS)
`endif

// >>> hw/ofr_pkg.sv
package ofr_pkg;
	typedef enum logic [1:0] {
		OFR_RESP_IGNORE   = 2'h0,
		OFR_RESP_DEGLITCH = 2'h1,
		OFR_RESP_SHUTDOWN = 2'h2,
		OFR_RESP_BAD      = 2'h3
	} ofr_resp_t;

	typedef enum logic [4:0] {
		OFR_ST_OFF    = 5'h01,
		OFR_ST_RUN    = 5'h02,
		OFR_ST_DELAY  = 5'h04,
		OFR_ST_LATCH  = 5'h08,
		OFR_ST_RETRY  = 5'h10
	} ofr_state_t;
endpackage

// >>> hw/ofr_dly_if.sv
interface ofr_dly_if;
	logic       start;
	logic       abort;
	logic [2:0] units;
	logic       busy;
	logic       expired;

	modport ctrl (output start, output abort, output units, input busy, input expired);
	modport tmr  (input start, input abort, input units, output busy, output expired);
endinterface

// >>> hw/ofr_delay.sv
`include "ofr_cfg.svh"

module ofr_delay (
	input  wire logic clk,
	input  wire logic rst,
	ofr_dly_if.tmr    dly
);
	localparam int STEP_CYC = `OFR_DLY_STEP_CYC;

	logic [7:0] pre_q;
	logic [2:0] left_q;
	logic       busy_q;
	logic       exp_q;
	logic       tick;

	// One-cycle enable every 10 us while a delay runs
	assign tick = busy_q && (pre_q == 8'(STEP_CYC - 1));

	always_ff @(posedge clk) begin
		if (rst || dly.start || !busy_q || tick) begin
			pre_q <= 8'h00;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		exp_q <= 1'b0;
		if (rst || dly.abort) begin
			busy_q <= 1'b0;
			left_q <= 3'h0;
		end else if (dly.start) begin
			// A zero field expires at once: no deglitch time at all
			busy_q <= (dly.units != 3'h0);
			left_q <= dly.units;
			exp_q  <= (dly.units == 3'h0);
		end else if (tick) begin
			left_q <= left_q - 3'h1;
			if (left_q == 3'h1) begin
				busy_q <= 1'b0;
				exp_q  <= 1'b1;
			end
		end
	end

	assign dly.busy    = busy_q;
	assign dly.expired = exp_q;
endmodule

// >>> hw/ofr_top.sv
`include "ofr_cfg.svh"

module ofr_top (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       cmd_wr,
	input  wire logic       cmd_rd,
	input  wire logic [7:0] cmd_code,
	input  wire logic [7:0] cmd_wdata,
	input  wire logic       clear_faults,
	input  wire logic       channel_run_pin,
	input  wire logic       operation_on,
	input  wire logic       ton_delay_done,
	input  wire logic       ton_rise_active,
	input  wire logic       toff_fall_active,
	input  wire logic       ton_max_window_done,
	input  wire logic [9:0] ton_max_limit,
	input  wire logic       ton_timeout,
	input  wire logic       vout_above_uv,
	input  wire logic       vout_below_uv,
	input  wire logic       oc_present,
	input  wire logic       restart_interval_done,
	output logic            output_enable_q,
	output logic            retry_start_q,
	output logic            alert_q,
	output logic            status_word_vout_q,
	output logic            status_vout_uv_q,
	output logic            status_vout_ton_q,
	output logic            status_byte_nota_q,
	output logic            cml_fault_q,
	output logic [7:0]      rd_data_q,
	output logic            rd_valid_q
);
	ofr_dly_if dly ();

	ofr_delay u_delay (
		.clk (clk),
		.rst (rst),
		.dly (dly)
	);

	ofr_pkg::ofr_state_t state_q;
	ofr_pkg::ofr_state_t state_d;

	logic [7:0] oc_resp_q;
	logic [7:0] uv_resp_q;
	logic       active;
	logic       active_q;
	logic       turn_on;
	logic       armed_q;
	logic       uv_det;
	logic       uv_det_q;
	logic       uv_event;
	logic       ton_event;
	logic       status_clr;
	logic       wr_bad;
	logic       dly_start;
	logic       dly_abort;
	logic       shut_now;
	logic       wr_oc_ok;
	logic       wr_uv_ok;
	logic       uv_mask_open;
	logic       sticky_any;
	logic       timer_lost;
	logic [7:0] uv_resp_hold_q;
	logic [7:0] resp_used;

	// Response field of a stored or written byte
	function automatic ofr_pkg::ofr_resp_t resp_of(input logic [7:0] b);
		resp_of = ofr_pkg::ofr_resp_t'(b[`OFR_RESP_HI:`OFR_RESP_LO]);
	endfunction

	// Retry field asks for endless restarts
	function automatic logic retry_forever(input logic [7:0] b);
		retry_forever = (b[`OFR_RETRY_HI:`OFR_RETRY_LO] == `OFR_RETRY_FOREVER);
	endfunction

	// States in which the power stage keeps running
	function automatic logic drives_output(input ofr_pkg::ofr_state_t s);
		drives_output = (s == ofr_pkg::OFR_ST_RUN) || (s == ofr_pkg::OFR_ST_DELAY);
	endfunction

	// Legality of a response byte for a given command
	function automatic logic resp_legal(input logic [7:0] code, input logic [7:0] b);
		if (code == `OFR_CMD_UV_RESP) begin
			resp_legal = (resp_of(b) != ofr_pkg::OFR_RESP_BAD);
		end else begin
			// The overcurrent byte refuses the deglitch code instead
			resp_legal = (resp_of(b) != ofr_pkg::OFR_RESP_DEGLITCH);
		end
	endfunction

	assign active  = channel_run_pin && operation_on;
	assign turn_on = active && !active_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			active_q <= 1'b0;
		end else begin
			active_q <= active;
		end
	end

	// Command writes; a refused byte never reaches the stored setting
	assign wr_oc_ok = cmd_wr && (cmd_code == `OFR_CMD_OC_RESP) &&
		resp_legal(cmd_code, cmd_wdata);
	assign wr_uv_ok = cmd_wr && (cmd_code == `OFR_CMD_UV_RESP) &&
		resp_legal(cmd_code, cmd_wdata);
	assign wr_bad   = cmd_wr && !wr_oc_ok && !wr_uv_ok;

	always_ff @(posedge clk) begin
		if (rst) begin
			oc_resp_q <= `OFR_OC_RESP_RST;
		end else if (wr_oc_ok) begin
			oc_resp_q <= cmd_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			uv_resp_q <= `OFR_UV_RESP_RST;
		end else if (wr_uv_ok) begin
			uv_resp_q <= cmd_wdata;
		end
	end

	// The delay path keeps the byte seen at detection, so a rewrite
	// during the delay cannot change how it ends
	always_ff @(posedge clk) begin
		if (rst) begin
			uv_resp_hold_q <= `OFR_UV_RESP_RST;
		end else if (dly_start) begin
			uv_resp_hold_q <= uv_resp_q;
		end
	end

	assign resp_used = (state_q == ofr_pkg::OFR_ST_DELAY) ? uv_resp_hold_q : uv_resp_q;

	// Command reads; unknown codes read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_q  <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= cmd_rd;
			if (cmd_rd) begin
				unique case (cmd_code)
					`OFR_CMD_OC_RESP: rd_data_q <= oc_resp_q;
					`OFR_CMD_UV_RESP: rd_data_q <= uv_resp_q;
					default:          rd_data_q <= 8'h00;
				endcase
			end
		end
	end

	// Arming of undervoltage detection after a clean start
	always_ff @(posedge clk) begin
		if (rst || !active || retry_start_q) begin
			armed_q <= 1'b0;
		end else if (ton_max_window_done && ton_delay_done && !ton_rise_active &&
				vout_above_uv && !oc_present) begin
			armed_q <= 1'b1;
		end
	end

	// Ramps and overcurrent keep the mask closed even once armed
	assign uv_mask_open = armed_q && active && drives_output(state_q) &&
		!ton_rise_active && !toff_fall_active && !oc_present;
	assign uv_det       = uv_mask_open && vout_below_uv;

	always_ff @(posedge clk) begin
		if (rst) begin
			uv_det_q <= 1'b0;
		end else begin
			uv_det_q <= uv_det;
		end
	end

	assign uv_event  = uv_det && !uv_det_q;
	assign ton_event = ton_timeout && (ton_max_limit != 10'h000);

	// Off-then-on or clear command wipes the sticky bits
	assign status_clr = clear_faults || turn_on;

	// Sticky status; a new event in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			status_vout_uv_q <= 1'b0;
		end else if (uv_event) begin
			status_vout_uv_q <= 1'b1;
		end else if (status_clr) begin
			status_vout_uv_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_vout_ton_q  <= 1'b0;
			status_byte_nota_q <= 1'b0;
		end else if (ton_event) begin
			status_vout_ton_q  <= 1'b1;
			status_byte_nota_q <= 1'b1;
		end else if (status_clr) begin
			status_vout_ton_q  <= 1'b0;
			status_byte_nota_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_word_vout_q <= 1'b0;
		end else if (uv_event || ton_event) begin
			status_word_vout_q <= 1'b1;
		end else if (status_clr) begin
			status_word_vout_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cml_fault_q <= 1'b0;
		end else if (wr_bad) begin
			cml_fault_q <= 1'b1;
		end else if (clear_faults) begin
			cml_fault_q <= 1'b0;
		end
	end

	// Alert holds while any sticky bit stands and drops with its clear
	assign sticky_any = status_vout_uv_q || status_vout_ton_q ||
		status_word_vout_q || status_byte_nota_q;

	// Alert follows any sticky bit, one cycle behind the event
	always_ff @(posedge clk) begin
		if (rst) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= uv_event || ton_event || wr_bad ||
				(!status_clr && sticky_any) ||
				(!clear_faults && cml_fault_q);
		end
	end

	// A timer that stops without expiring would strand the channel in the
	// delay state, so that case ends the delay like an expiry
	assign timer_lost = !dly.busy && !dly.expired;

	// Response state machine
	always_comb begin
		state_d   = state_q;
		dly_start = 1'b0;
		dly_abort = 1'b0;
		shut_now  = 1'b0;
		unique case (state_q)
			ofr_pkg::OFR_ST_OFF: begin
				// Start or restart once the channel is on
				if (active) begin
					state_d = ofr_pkg::OFR_ST_RUN;
				end
			end
			ofr_pkg::OFR_ST_RUN: begin
				if (uv_event) begin
					unique case (resp_of(uv_resp_q))
						ofr_pkg::OFR_RESP_DEGLITCH: begin
							dly_start = 1'b1;
							state_d   = ofr_pkg::OFR_ST_DELAY;
						end
						ofr_pkg::OFR_RESP_SHUTDOWN: begin
							shut_now = 1'b1;
						end
						ofr_pkg::OFR_RESP_IGNORE: begin
							state_d = ofr_pkg::OFR_ST_RUN;
						end
						// Stored 11 cannot occur: such a write is refused
						default: state_d = ofr_pkg::OFR_ST_RUN;
					endcase
				end
			end
			ofr_pkg::OFR_ST_DELAY: begin
				// Fault gone before expiry: resume without a shutdown
				if (!uv_det) begin
					dly_abort = 1'b1;
					state_d   = ofr_pkg::OFR_ST_RUN;
				end else if (dly.expired || timer_lost) begin
					shut_now = 1'b1;
				end
			end
			ofr_pkg::OFR_ST_LATCH: begin
				// Clear or off releases a latched shutdown
				if (clear_faults) begin
					state_d = ofr_pkg::OFR_ST_OFF;
				end
			end
			ofr_pkg::OFR_ST_RETRY: begin
				// Spacing comes from the restart interval setting outside
				if (restart_interval_done) begin
					state_d = ofr_pkg::OFR_ST_OFF;
				end
			end
			default: state_d = ofr_pkg::OFR_ST_OFF;
		endcase
		if (shut_now) begin
			state_d = retry_forever(resp_used) ? ofr_pkg::OFR_ST_RETRY :
				ofr_pkg::OFR_ST_LATCH;
		end
		// Commanding the channel off overrides every response
		if (!active) begin
			dly_abort = (state_q == ofr_pkg::OFR_ST_DELAY);
			state_d   = ofr_pkg::OFR_ST_OFF;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ofr_pkg::OFR_ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	assign dly.start = dly_start;
	assign dly.abort = dly_abort;
	assign dly.units = uv_resp_q[`OFR_DLY_HI:`OFR_DLY_LO];

	// Output stays on in run and deglitch, off once shut down
	always_ff @(posedge clk) begin
		if (rst) begin
			output_enable_q <= 1'b0;
		end else begin
			output_enable_q <= drives_output(state_d);
		end
	end

	// Pulse that tells the sequencer a retry restart begins
	always_ff @(posedge clk) begin
		if (rst) begin
			retry_start_q <= 1'b0;
		end else begin
			retry_start_q <= (state_q == ofr_pkg::OFR_ST_RETRY) &&
				restart_interval_done && active;
		end
	end
endmodule

// >>> sim/ofr_chk.sv
module ofr_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_rd,
	input wire logic clear_faults,
	input wire logic channel_run_pin,
	input wire logic operation_on,
	input wire logic ton_rise_active,
	input wire logic toff_fall_active,
	input wire logic output_enable_q,
	input wire logic retry_start_q,
	input wire logic alert_q,
	input wire logic status_word_vout_q,
	input wire logic status_vout_uv_q,
	input wire logic status_vout_ton_q,
	input wire logic status_byte_nota_q,
	input wire logic cml_fault_q,
	input wire logic rd_valid_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic act;
	assign act = channel_run_pin && operation_on;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_read_answer: assert property (cmd_rd |=> rd_valid_q)
		else $error("read not answered");
	chk_uv_flags: assert property ($rose(status_vout_uv_q) |-> status_word_vout_q && alert_q)
		else $error("uv flags incomplete");
	chk_ton_flags: assert property ($rose(status_vout_ton_q) |->
		status_byte_nota_q && status_word_vout_q && alert_q)
		else $error("timeout flags incomplete");
	chk_uv_inactive: assert property ($rose(status_vout_uv_q) |-> $past(act))
		else $error("uv seen while inactive");
	chk_uv_ramp: assert property ($rose(status_vout_uv_q) |->
		$past(!ton_rise_active && !toff_fall_active))
		else $error("uv seen during ramp");
	// Two cycles of history keep an off-on clear from looking like a lost bit
	chk_uv_sticky: assert property (status_vout_uv_q && !clear_faults && act &&
		$past(act) && $past(act, 2) |=> status_vout_uv_q)
		else $error("uv bit dropped");
	chk_off_cause: assert property ($fell(output_enable_q) && act && $past(act) &&
		$past(act, 2) |-> status_vout_uv_q || status_vout_ton_q)
		else $error("output dropped without fault");
	chk_cml_alert: assert property ($rose(cml_fault_q) |-> alert_q)
		else $error("cml without alert");
	chk_retry_pulse: assert property (retry_start_q |=> !retry_start_q)
		else $error("retry pulse too long");
	cover property ($rose(status_vout_uv_q));
	cover property ($rose(status_vout_ton_q));
	cover property ($rose(cml_fault_q));
	cover property (retry_start_q);
endmodule

// >>> sim/ofr_host.sv
module ofr_host (
	input  wire logic       clk,
	input  wire logic       rd_valid_q,
	input  wire logic [7:0] rd_data_q,
	output logic            cmd_wr,
	output logic            cmd_rd,
	output logic [7:0]      cmd_code,
	output logic [7:0]      cmd_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = 18'h000ff;
	// Idle lines show the inverse so stale values are never mistaken
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(negedge clk);
		{cmd_wr, cmd_code, cmd_wdata} = {1'b1, c, d};
		@(negedge clk);
		{cmd_wr, cmd_code, cmd_wdata} = {1'b0, ~c, ~d};
	endtask
	task automatic rd(input logic [7:0] c, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		@(negedge clk);
		{cmd_rd, cmd_code} = {1'b1, c};
		@(negedge clk);
		{cmd_rd, cmd_code} = {1'b0, ~c};
		// The answer stands for one cycle only, starting at the edge just passed
		for (int i = 0; i < 4 && !ok; i++) begin
			ok = (rd_valid_q === 1'b1);
			if (!ok)
				@(negedge clk);
		end
		d = rd_data_q;
	endtask
endmodule

// >>> sim/output_fault_response_control_tb.sv
`include "ofr_cfg.svh"
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch t=%0t %s", $time, m); end end

module output_fault_response_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, clear_faults, channel_run_pin, operation_on, ton_delay_done, cmd_wr, cmd_rd;
	logic ton_rise_active, toff_fall_active, ton_max_window_done, ton_timeout, vout_above_uv;
	logic vout_below_uv, oc_present, restart_interval_done, output_enable_q, retry_start_q;
	logic alert_q, status_word_vout_q, status_vout_uv_q, status_vout_ton_q, status_byte_nota_q;
	logic cml_fault_q, rd_valid_q;
	logic [7:0] cmd_code, cmd_wdata, rd_data_q, rv;
	logic [9:0] ton_max_limit;
	int         n_fail, total_checks;
	bit         ok;
	ofr_top dut_u (.clk, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .clear_faults,
		.channel_run_pin, .operation_on, .ton_delay_done, .ton_rise_active, .toff_fall_active,
		.ton_max_window_done, .ton_max_limit, .ton_timeout, .vout_above_uv, .vout_below_uv,
		.oc_present, .restart_interval_done, .output_enable_q, .retry_start_q, .alert_q,
		.status_word_vout_q, .status_vout_uv_q, .status_vout_ton_q, .status_byte_nota_q,
		.cml_fault_q, .rd_data_q, .rd_valid_q);
	ofr_host host_u (.clk, .rd_valid_q, .rd_data_q, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rchk(input logic [7:0] c, input logic [7:0] e);
		host_u.rd(c, rv, ok);
		`CHK(ok, 1'b1, "no read answer")
		`CHK(rv, e, "read data")
	endtask
	task automatic clr();
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
		cyc(1);
	endtask
	task automatic wait_oe(input logic v, input int n);
		for (int i = 0; i < n && output_enable_q !== v; i++) cyc(1);
		`CHK(output_enable_q, v, "output enable")
		if (output_enable_q !== v)
			report_and_stop();
	endtask
	initial begin
		{clear_faults, channel_run_pin, operation_on, ton_delay_done, ton_rise_active,
			toff_fall_active, ton_max_window_done, ton_timeout, vout_above_uv, vout_below_uv,
			oc_present, restart_interval_done} = 12'h000;
		ton_max_limit = 10'h000;
		rst = 1'b1;
		cyc(6);
		rst = 1'b0;
		rchk(`OFR_CMD_OC_RESP, `OFR_OC_RESP_RST);
		host_u.wr(`OFR_CMD_OC_RESP, 8'h40);
		host_u.wr(`OFR_CMD_UV_RESP, 8'h7a);
		rchk(`OFR_CMD_OC_RESP, 8'h00);
		`CHK(cml_fault_q, 1'b1, "oc code refused")
		host_u.wr(`OFR_CMD_UV_RESP, 8'hc1);
		rchk(`OFR_CMD_UV_RESP, 8'h7a);
		clr();
		`CHK(cml_fault_q, 1'b0, "cml cleared")
		host_u.wr(`OFR_CMD_UV_RESP, 8'h00);
		$display("test commands done");
		{channel_run_pin, operation_on, ton_delay_done, vout_below_uv} = 4'hf;
		cyc(10);
		`CHK(status_vout_uv_q, 1'b0, "early uv")
		{vout_below_uv, vout_above_uv, ton_max_window_done} = 3'b011;
		wait_oe(1'b1, 20);
		{toff_fall_active, vout_below_uv} = 2'b11;
		cyc(5);
		`CHK(status_vout_uv_q, 1'b0, "uv in ramp")
		toff_fall_active = 1'b0;
		cyc(2);
		`CHK({status_vout_uv_q, status_word_vout_q, alert_q}, 3'h7, "uv flags")
		`CHK(output_enable_q, 1'b1, "ignore response")
		vout_below_uv = 1'b0;
		clr();
		`CHK(status_vout_uv_q, 1'b0, "uv cleared")
		`CHK(alert_q, 1'b0, "alert cleared")
		$display("test masking done");
		host_u.wr(`OFR_CMD_UV_RESP, 8'h80);
		vout_below_uv = 1'b1;
		cyc(2);
		`CHK(output_enable_q, 1'b0, "shutdown")
		{vout_below_uv, restart_interval_done} = 2'b01;
		cyc(20);
		`CHK(output_enable_q, 1'b0, "no restart")
		restart_interval_done = 1'b0;
		clr();
		wait_oe(1'b1, 10);
		host_u.wr(`OFR_CMD_UV_RESP, 8'hb8);
		vout_below_uv = 1'b1;
		cyc(2);
		`CHK(output_enable_q, 1'b0, "retry shutdown")
		vout_below_uv = 1'b0;
		cyc(5);
		`CHK(output_enable_q, 1'b0, "waits interval")
		restart_interval_done = 1'b1;
		cyc(1);
		`CHK(retry_start_q, 1'b1, "retry pulse")
		wait_oe(1'b1, 10);
		`CHK(retry_start_q, 1'b0, "retry pulse ends")
		restart_interval_done = 1'b0;
		clr();
		$display("test shutdown done");
		// One delay unit is 200 cycles at this clock
		host_u.wr(`OFR_CMD_UV_RESP, 8'h41);
		cyc(5);
		vout_below_uv = 1'b1;
		cyc(190);
		`CHK(output_enable_q, 1'b1, "delay running")
		wait_oe(1'b0, 20);
		vout_below_uv = 1'b0;
		clr();
		wait_oe(1'b1, 10);
		vout_below_uv = 1'b1;
		cyc(100);
		vout_below_uv = 1'b0;
		cyc(200);
		`CHK(output_enable_q, 1'b1, "fault gone")
		clr();
		$display("test delay done");
		ton_timeout = 1'b1;
		cyc(1);
		ton_timeout = 1'b0;
		cyc(2);
		`CHK(status_vout_ton_q, 1'b0, "zero limit")
		ton_max_limit = 10'h00a;
		ton_timeout = 1'b1;
		cyc(1);
		ton_timeout = 1'b0;
		cyc(2);
		`CHK({status_vout_ton_q, status_byte_nota_q, status_word_vout_q, alert_q}, 4'hf, "ton")
		{channel_run_pin, vout_below_uv} = 2'b01;
		cyc(5);
		`CHK(status_vout_uv_q, 1'b0, "uv inactive")
		{channel_run_pin, vout_below_uv} = 2'b10;
		cyc(3);
		`CHK(status_vout_ton_q, 1'b0, "off on clears")
		$display("test timeout done");
		report_and_stop();
	end
endmodule

bind ofr_top ofr_chk chk_u (.clk, .rst, .cmd_rd, .clear_faults, .channel_run_pin, .operation_on,
	.ton_rise_active, .toff_fall_active, .output_enable_q, .retry_start_q, .alert_q,
	.status_word_vout_q, .status_vout_uv_q, .status_vout_ton_q, .status_byte_nota_q,
	.cml_fault_q, .rd_valid_q);
